//--- sim/fast_io_unit_sva.sv
// port checker for the fast i/o unit
`timescale 1ns/100ps
module fast_io_unit_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and core side
  input wire logic [3:0] hs_input,
  input wire logic [1:0] hs_output,
  input wire logic [3:0] core_in,
  input wire logic [1:0] core_out,
  input wire logic irq
);
  import fast_io_pkg::*;
  logic wr_ph_r;
  logic [11:0] wr_addr_r;
  logic [7:0] mode_r;
  logic [9:0] ctrl_r;
  logic [4:0] mask_r;
  wire st_wr = wr_ph_r && wr_addr_r == OFS_STATUS;

  // shadow of the registers that steer the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      wr_addr_r <= 12'h000;
      mode_r <= MODE_FILT;
      ctrl_r <= CTRL_RST;
      mask_r <= 5'h00;
    end else begin
      wr_ph_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= {haddr[11:2], 2'b00};
      if (wr_ph_r && wr_addr_r == OFS_MODE) mode_r <= hwdata[7:0];
      if (wr_ph_r && wr_addr_r == OFS_CTRL) ctrl_r <= hwdata[9:0];
      if (wr_ph_r && wr_addr_r == OFS_MASK) mask_r <= hwdata[4:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  out_regular_a: assert property (
    mode_r != MODE_PULSE && $past(mode_r) != MODE_PULSE && $past(mode_r, 2) != MODE_PULSE
    |-> hs_output == $past(core_out)) else $error("output not following core");
  pulse_dir_a: assert property (
    mode_r == MODE_PULSE && !ctrl_r[CTRL_CWCCW] && $rose(hs_output[0]) |-> hs_output[1] == ctrl_r[CTRL_DIR])
    else $error("direction line wrong at pulse");
  cw_ccw_a: assert property (
    mode_r == MODE_PULSE && ctrl_r[CTRL_CWCCW] && $past(ctrl_r, 2) == ctrl_r |-> !hs_output[!ctrl_r[CTRL_DIR]])
    else $error("pulse on the idle direction line");
  catch_seen_a: assert property (
    mode_r == MODE_CATCH && $past(mode_r) == MODE_CATCH && $rose(hs_input[0]) |-> ##[1:5] core_in[0])
    else $error("short pulse not caught");
  catch_hold_a: assert property (
    mode_r == MODE_CATCH && $past(mode_r) == MODE_CATCH && core_in[0] && !st_wr && !$past(st_wr)
    && !$past(st_wr, 2) |=> core_in[0]) else $error("caught pulse dropped");
  irq_mask_a: assert property (
    mask_r == 5'h00 && $past(mask_r) == 5'h00 && $past(mask_r, 2) == 5'h00 |-> !irq)
    else $error("interrupt with all masked");
  edge_irq_a: assert property (
    mode_r == MODE_INT && mask_r[ST_EDGE] && ctrl_r[7:6] == 2'b00 && $rose(hs_input[0]) |-> ##[1:6] irq)
    else $error("edge interrupt missing");
endmodule : fast_io_unit_sva

bind fast_io_unit fast_io_unit_sva chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hs_input, .hs_output, .core_in, .core_out, .irq);

//--- sim/fast_io_unit_tb_top.sv
// self-checking bench for the fast i/o unit
`timescale 1ns/100ps
module fast_io_unit_tb_top;
  import fast_io_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] core_out = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hready, hreadyout, hresp, irq;
  logic [31:0] hrdata, q;
  logic [3:0] hs_input, core_in, v;
  logic [1:0] hs_output;
  int failures = 0;
  int checks_done = 0;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  fast_io_unit #(.TICK_CYC(10), .PULSE_MIN_CYC(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .hs_input, .hs_output, .core_in, .core_out, .irq);
  field_model fld (.hclk, .hs_input, .hs_output);

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_MODE, 32'h60);
    rd(OFS_FILT, 32'ha0a);
    rd(12'h02c, 32'h0);
    fld.set_lvl(4'hf);
    wt(50);
    chk(32'(core_in), 32'h0);
    wt(90);
    chk(32'(core_in), 32'hf);
    $display("test defaults done");
    wr(OFS_FILT, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_MODE, i ? 32'h35 : 32'h60);
      v = i ? 4'ha : 4'h5;
      fld.set_lvl(v);
      core_out <= v[1:0];
      wt(4);
      chk(32'(core_in), 32'(v));
      chk(32'(hs_output), 32'(v[1:0]));
    end
    fld.set_lvl(4'h0);
    core_out <= 2'h0;
    $display("test pass-through done");
    wr(OFS_MODE, 32'h10);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_PIDX, 32'h0);
    wr(OFS_PRESET, 32'h3);
    wr(OFS_PRESET, PRESET_END);
    wr(OFS_MASK, 32'h1);
    fld.pulse(1, 4, 2);
    fld.pulse(0, 4, 3);
    wt(4);
    rd(OFS_COUNT, 32'h3);
    chk(32'(irq), 32'h1);
    wr(OFS_STATUS, 32'h1f);
    wt(3);
    chk(32'(irq), 32'h0);
    fld.pulse(2, 4, 1);
    wt(4);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h0);
    fld.pulse(0, 4, 2);
    fld.pulse(2, 4, 1);
    wt(4);
    rd(OFS_COUNT, 32'h2);
    $display("test up counter done");
    wr(OFS_MODE, 32'h20);
    wr(OFS_CTRL, 32'h3);
    fld.quad(1'b1, 8);
    fld.quad(1'b0, 3);
    wt(6);
    rd(OFS_COUNT, 32'h5);
    $display("test quadrature done");
    fld.set_lvl(4'h0);
    wr(OFS_MODE, 32'h40);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_MASK, 32'h2);
    fld.pulse(0, 4, 1);
    wt(2);
    chk(32'(irq), 32'h1);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_CTRL, 32'h81);
    wr(OFS_STATUS, 32'h1f);
    fld.set_lvl(4'h1);
    wt(4);
    rd(OFS_STATUS, 32'h0);
    fld.set_lvl(4'h0);
    wt(4);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_TIMER, 32'h2);
    wr(OFS_CTRL, 32'h41);
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_MASK, 32'h4);
    wt(40);
    bus(OFS_STATUS, 1'b0, 32'h0);
    chk(q & 32'h4, 32'h4);
    $display("test interrupt done");
    wr(OFS_MODE, 32'h50);
    wr(OFS_MASK, 32'h0);
    wr(OFS_STATUS, 32'h1f);
    fld.pulse(0, 1, 1);
    wt(3);
    chk(32'(core_in[0]), 32'h1);
    rd(OFS_STATUS, 32'h8);
    wr(OFS_STATUS, 32'h8);
    wt(4);
    chk(32'(core_in[0]), 32'h0);
    $display("test pulse catch done");
    // only the pulse function is enabled from here on
    wr(OFS_MODE, 32'h30);
    wr(OFS_PERIOD, 32'h4);
    wr(OFS_PULSES, 32'h5);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CTRL, k ? 32'h031 : 32'h011);
      wr(OFS_STATUS, 32'h1f);
      fld.clr();
      wr(OFS_CTRL, k ? 32'h035 : 32'h015);
      q = 32'h0;
      for (int i = 0; i < 200 && q[ST_DONE] !== 1'b1; i++) bus(OFS_STATUS, 1'b0, 32'h0);
      chk(q & 32'h10, 32'h10);
      chk(k ? fld.cnt1 : fld.cnt0, 32'h5);
    end
    // velocity runs until stopped
    wr(OFS_CTRL, 32'h211);
    wr(OFS_STATUS, 32'h1f);
    fld.clr();
    wr(OFS_CTRL, 32'h215);
    wt(60);
    rd(OFS_STATUS, 32'h0);
    chk(32'(fld.cnt0 > 5), 32'h1);
    wr(OFS_CTRL, 32'h219);
    wt(4);
    fld.clr();
    wt(20);
    chk(fld.cnt0, 32'h0);
    // registration counts only after the trigger input rises
    wr(OFS_CTRL, 32'h111);
    wr(OFS_STATUS, 32'h1f);
    wr(OFS_CTRL, 32'h115);
    wt(30);
    rd(OFS_STATUS, 32'h0);
    fld.pulse(2, 4, 1);
    q = 32'h0;
    for (int i = 0; i < 200 && q[ST_DONE] !== 1'b1; i++) bus(OFS_STATUS, 1'b0, 32'h0);
    chk(q & 32'h10, 32'h10);
    $display("test pulse output done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    wrap_up();
  end
endmodule : fast_io_unit_tb_top

//--- sim/field_model.sv
// field side: sensors on the fast inputs, a drive counting output pulses
`timescale 1ns/100ps
module field_model (
  // clock
  input wire logic hclk,
  // pins
  output logic [3:0] hs_input,
  input wire logic [1:0] hs_output
);
  int cnt0 = 0;
  int cnt1 = 0;
  logic [1:0] qph = 2'h0;
  logic [1:0] out_d = 2'h0;

  initial hs_input = 4'h0;

  // drive counts rising edges on each line
  always @(posedge hclk) begin
    out_d <= hs_output;
    if (hs_output[0] && !out_d[0]) cnt0 <= cnt0 + 1;
    if (hs_output[1] && !out_d[1]) cnt1 <= cnt1 + 1;
  end

  task automatic clr();
    @(posedge hclk);
    cnt0 <= 0;
    cnt1 <= 0;
  endtask : clr

  task automatic set_lvl(input logic [3:0] v);
    @(posedge hclk);
    hs_input <= v;
  endtask : set_lvl

  // pulses of w cycles high and w+1 low between them, never narrower than the catch limit
  task automatic pulse(input int ch, input int w, input int n);
    repeat (n) begin
      @(posedge hclk);
      hs_input[ch] <= 1'b1;
      repeat (w) @(posedge hclk);
      hs_input[ch] <= 1'b0;
      repeat (w) @(posedge hclk);
    end
  endtask : pulse

  // two-phase encoder, phase a leads for up, one edge per step
  task automatic quad(input bit up, input int n);
    repeat (n) begin
      repeat (4) @(posedge hclk);
      qph = up ? qph + 2'h1 : qph - 2'h1;
      hs_input[1:0] <= {qph[1], qph[1] ^ qph[0]};
    end
  endtask : quad
endmodule : field_model

//--- verilog/fast_io_pkg.sv
// constants, register map and types of the fast i/o unit
package fast_io_pkg;
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int PULSE_MAX_HZ = 7000;
  localparam int PULSE_MIN_CYCLES = (CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ;
  localparam logic [6:0] FILTER_MAX_MS = 7'h63;
  localparam int PRESET_DEPTH = 24;
  localparam logic [31:0] PRESET_END = 32'h0000_ffff;

  // register byte offsets
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_CTRL = 12'h004;
  localparam logic [11:0] OFS_FILT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_MASK = 12'h010;
  localparam logic [11:0] OFS_COUNT = 12'h014;
  localparam logic [11:0] OFS_PERIOD = 12'h018;
  localparam logic [11:0] OFS_PULSES = 12'h01c;
  localparam logic [11:0] OFS_TIMER = 12'h020;
  localparam logic [11:0] OFS_PRESET = 12'h024;
  localparam logic [11:0] OFS_PIDX = 12'h028;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0060;
  localparam logic [15:0] FILT_RST = 16'h0a0a;
  localparam logic [9:0] CTRL_RST = 10'h001;
  localparam logic [31:0] PERIOD_RST = 32'h0000_45c2;
  localparam logic [31:0] PULSES_RST = 32'h0000_0000;
  localparam logic [15:0] TIMER_RST = 16'h000a;

  // mode codes, two bcd digits in the low byte
  localparam logic [7:0] MODE_UP = 8'h10;
  localparam logic [7:0] MODE_QUAD = 8'h20;
  localparam logic [7:0] MODE_PULSE = 8'h30;
  localparam logic [7:0] MODE_INT = 8'h40;
  localparam logic [7:0] MODE_CATCH = 8'h50;
  localparam logic [7:0] MODE_FILT = 8'h60;

  // control bits
  localparam int CTRL_X2_RESET = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_START = 2;
  localparam int CTRL_STOP = 3;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_CWCCW = 5;
  localparam int CTRL_TIMED = 6;
  localparam int CTRL_FALLING = 7;
  localparam int CTRL_PROF = 8;

  // profile codes
  localparam logic [1:0] PROF_TRAP = 2'h0;
  localparam logic [1:0] PROF_REG = 2'h1;
  localparam logic [1:0] PROF_VEL = 2'h2;

  // status and mask bits
  localparam int ST_PRESET = 0;
  localparam int ST_EDGE = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_CATCH = 3;
  localparam int ST_DONE = 4;
  localparam int ST_W = 5;

  typedef enum logic [2:0] {M_PASS, M_UP, M_QUAD, M_PULSE, M_INT, M_CATCH} mode_t;
  typedef enum logic [1:0] {P_IDLE, P_RUN} pulse_state_t;
endpackage : fast_io_pkg

//--- verilog/fast_io_unit.sv
// fast i/o unit: mode router, counters, pulse output, interrupts, filters
//
// Functional notes
// - only inputs 0-3 and outputs 0-1 handled here
// - mode 60 passes points through the filters
// - functions run on own clock, scan-independent
// - six modes: codes 10,20,30,40,50,60
// - mode 10 up count, 24 presets, interrupt
// - pins used by a mode stay linked to the core, except input 0 in mode 50 and outputs in mode 30
// - mode 20 quadrature up/down count, reset
// - mode 30 pulse outputs, three profiles
// - mode 40 interrupt on edge or timer
// - mode 50 catches short input pulses
// - filters with on/off delays to 99ms
// - unused inputs filtered, outputs regular
// - mode 60 after reset
// - default filter 10ms, standard outputs
// - functions gated by input/output variant
// - mode in low byte of 16-bit word
// - pin reset only when configured so
`timescale 1ns/100ps
module fast_io_unit
  import fast_io_pkg::*;
#(
  parameter bit HAS_DC_INPUTS = 1'b1,
  parameter bit HAS_DC_OUTPUTS = 1'b1,
  parameter int TICK_CYC = fast_io_pkg::TICK_CYCLES,
  parameter int PULSE_MIN_CYC = fast_io_pkg::PULSE_MIN_CYCLES,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // field pins
  input wire logic [3:0] hs_input,
  output logic [1:0] hs_output,
  // controller core side
  output logic [3:0] core_in,
  input wire logic [1:0] core_out,
  // interrupt
  output logic irq
);
  import fast_io_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  function automatic mode_t decode_mode(input logic [7:0] code);
    case (code)
      MODE_UP: decode_mode = HAS_DC_INPUTS ? M_UP : M_PASS;
      MODE_QUAD: decode_mode = HAS_DC_INPUTS ? M_QUAD : M_PASS;
      MODE_PULSE: decode_mode = HAS_DC_OUTPUTS ? M_PULSE : M_PASS;
      MODE_INT: decode_mode = HAS_DC_INPUTS ? M_INT : M_PASS;
      MODE_CATCH: decode_mode = HAS_DC_INPUTS ? M_CATCH : M_PASS;
      MODE_FILT: decode_mode = M_PASS;
      default: decode_mode = M_PASS;
    endcase
  endfunction : decode_mode

  function automatic logic [6:0] clamp_ms(input logic [7:0] v);
    clamp_ms = (v > {1'b0, FILTER_MAX_MS}) ? FILTER_MAX_MS : v[6:0];
  endfunction : clamp_ms

  // registers
  logic [15:0] mode_r;
  logic [9:0] ctrl_r;
  logic [15:0] filt_cfg_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] status_nxt;
  logic [ST_W-1:0] mask_r;
  logic [31:0] period_r;
  logic [31:0] pulses_r;
  logic [15:0] timer_r;
  logic [4:0] pidx_r;

  // bus
  logic wr_pend_r;
  logic [11:0] waddr_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  wire acc = hsel & hready & htrans[1];
  wire [11:0] raddr = {haddr[11:2], 2'h0};
  wire wr_mode = wr_pend_r & (waddr_r == OFS_MODE);
  wire wr_ctrl = wr_pend_r & (waddr_r == OFS_CTRL);
  wire wr_filt = wr_pend_r & (waddr_r == OFS_FILT);
  wire wr_status = wr_pend_r & (waddr_r == OFS_STATUS);
  wire wr_mask = wr_pend_r & (waddr_r == OFS_MASK);
  wire wr_period = wr_pend_r & (waddr_r == OFS_PERIOD);
  wire wr_pulses = wr_pend_r & (waddr_r == OFS_PULSES);
  wire wr_timer = wr_pend_r & (waddr_r == OFS_TIMER);
  wire wr_preset = wr_pend_r & (waddr_r == OFS_PRESET);
  wire wr_pidx = wr_pend_r & (waddr_r == OFS_PIDX);
  wire sw_clear = wr_ctrl & hwdata[CTRL_CLEAR];
  wire sw_start = wr_ctrl & hwdata[CTRL_START];
  wire sw_stop = wr_ctrl & hwdata[CTRL_STOP];

  // mode decode of low byte only; upper byte kept for power-up options
  wire mode_t mode = decode_mode(mode_r[7:0]);
  wire is_up = (mode == M_UP);
  wire is_quad = (mode == M_QUAD);
  wire is_pulse = (mode == M_PULSE);
  wire is_int = (mode == M_INT);
  wire is_catch = (mode == M_CATCH);
  wire [1:0] prof = ctrl_r[CTRL_PROF+1:CTRL_PROF];

  // input sampling and millisecond tick
  logic [3:0] in_q;
  logic [3:0] in_d;
  logic [3:0] filt;
  logic [TW-1:0] tick_cnt_r;
  wire tick = (tick_cnt_r == TW'(TICK_CYC - 1));
  wire [6:0] on_ms = clamp_ms(filt_cfg_r[7:0]);
  wire [6:0] off_ms = clamp_ms(filt_cfg_r[15:8]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q <= 4'h0;
      in_d <= 4'h0;
      tick_cnt_r <= '0;
    end else begin
      in_q <= hs_input;
      in_d <= in_q;
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // per-pin filters: level must persist for the delay to pass
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      logic [6:0] age_r;
      logic lvl_r;
      wire differ = (in_q[gi] != lvl_r);
      wire [6:0] lim = in_q[gi] ? on_ms : off_ms;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          age_r <= 7'h00;
          lvl_r <= 1'b0;
        end else if (!differ) begin
          age_r <= 7'h00;
        end else if (age_r >= lim) begin
          lvl_r <= in_q[gi];
          age_r <= 7'h00;
        end else if (tick) begin
          age_r <= age_r + 7'h01;
        end
      end
      assign filt[gi] = lvl_r;
    end
  endgenerate

  // counter for modes 10 and 20
  logic [CNT_W-1:0] count_r;
  wire up_edge = in_q[0] & ~in_d[0];
  wire a_chg = in_q[0] ^ in_d[0];
  wire b_chg = in_q[1] ^ in_d[1];
  wire quad_step = a_chg ^ b_chg;
  wire quad_up = ~(in_d[0] ^ in_q[1]);
  wire pin_reset = (is_up | is_quad) & ctrl_r[CTRL_X2_RESET] & in_q[2] & ~in_d[2];
  wire cnt_reset = pin_reset | sw_clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
    end else if (cnt_reset) begin
      count_r <= '0;
    end else if (is_up && up_edge) begin
      count_r <= count_r + CNT_W'(1);
    end else if (is_quad && quad_step) begin
      count_r <= quad_up ? count_r + CNT_W'(1) : count_r - CNT_W'(1);
    end
  end

  // preset table walk
  logic [4:0] preset_idx_r;
  logic look_r;
  logic [31:0] preset_q;
  wire preset_hit = is_up & look_r & (int'(preset_idx_r) < PRESET_DEPTH) &
                    (preset_q != PRESET_END) & (32'(count_r) == preset_q);

  preset_mem #(.WIDTH(32), .DEPTH(PRESET_DEPTH), .AW(5)) u_presets (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_preset),
    .wr_addr(pidx_r),
    .wr_data(hwdata),
    .rd_addr(preset_idx_r),
    .rd_data(preset_q)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_idx_r <= 5'h00;
      look_r <= 1'b0;
    end else if (cnt_reset || !is_up || wr_preset) begin
      preset_idx_r <= 5'h00;
      look_r <= 1'b0;
    end else if (preset_hit) begin
      preset_idx_r <= preset_idx_r + 5'h01;
      look_r <= 1'b0;
    end else begin
      look_r <= 1'b1;
    end
  end

  // mode 40 edge and timer events
  logic [15:0] tmr_ms_r;
  wire rise0 = in_q[0] & ~in_d[0];
  wire fall0 = ~in_q[0] & in_d[0];
  wire timed = ctrl_r[CTRL_TIMED];
  wire edge_evt = is_int & ~timed & (ctrl_r[CTRL_FALLING] ? fall0 : rise0);
  wire tmr_wrap = tick & ((tmr_ms_r + 16'h0001) >= timer_r);
  wire timer_evt = is_int & timed & (timer_r != 16'h0000) & tmr_wrap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_ms_r <= 16'h0000;
    end else if (!(is_int && timed)) begin
      tmr_ms_r <= 16'h0000;
    end else if (tick) begin
      tmr_ms_r <= tmr_wrap ? 16'h0000 : tmr_ms_r + 16'h0001;
    end
  end

  // mode 50 catch: any high of one clock or more is latched
  wire catch_evt = is_catch & rise0;

  // mode 30 pulse generator
  pulse_state_t p_state_r;
  logic [31:0] div_r;
  logic phase_r;
  logic counted_r;
  logic [31:0] remain_r;
  logic done_evt;
  logic g_trig_d;
  wire [31:0] period_eff = (period_r < 32'(PULSE_MIN_CYC)) ? 32'(PULSE_MIN_CYC) : period_r;
  wire [31:0] half = {1'b0, period_eff[31:1]};
  wire half_end = (div_r + 32'h1 >= half);
  wire period_end = half_end & phase_r;
  wire reg_trig = (prof == PROF_REG) & filt[2] & ~g_trig_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_state_r <= P_IDLE;
      div_r <= 32'h0;
      phase_r <= 1'b0;
      counted_r <= 1'b0;
      remain_r <= 32'h0;
      done_evt <= 1'b0;
      g_trig_d <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      g_trig_d <= filt[2];
      case (p_state_r)
        P_IDLE: begin
          div_r <= 32'h0;
          phase_r <= 1'b0;
          if (is_pulse && sw_start) begin
            counted_r <= (prof == PROF_TRAP);
            remain_r <= pulses_r;
            if ((prof == PROF_TRAP) && (pulses_r == 32'h0)) begin
              done_evt <= 1'b1;
            end else begin
              p_state_r <= P_RUN;
            end
          end
        end
        P_RUN: begin
          if (!is_pulse || sw_stop) begin
            p_state_r <= P_IDLE;
          end else begin
            div_r <= half_end ? 32'h0 : div_r + 32'h1;
            if (half_end) begin
              phase_r <= ~phase_r;
            end
            if (reg_trig && !counted_r) begin
              counted_r <= 1'b1;
              remain_r <= pulses_r;
            end else if (period_end && counted_r) begin
              remain_r <= remain_r - 32'h1;
              if (remain_r <= 32'h1) begin
                p_state_r <= P_IDLE;
                done_evt <= 1'b1;
              end
            end
          end
        end
        default: p_state_r <= P_IDLE;
      endcase
    end
  end

  // status, set wins over write-one-to-clear
  wire [ST_W-1:0] sets = {done_evt, catch_evt, timer_evt, edge_evt, preset_hit};
  wire [ST_W-1:0] w1c = wr_status ? hwdata[ST_W-1:0] : '0;
  assign status_nxt = (status_r & ~w1c) | sets;

  // pin routing
  wire dir = ctrl_r[CTRL_DIR];
  wire run = (p_state_r == P_RUN) & phase_r;
  wire [1:0] pulse_pins = ctrl_r[CTRL_CWCCW] ? {run & dir, run & ~dir} : {dir, run};
  wire [1:0] out_nxt = is_pulse ? pulse_pins : core_out;
  wire [3:0] in_nxt = {filt[3:1], is_catch ? status_r[ST_CATCH] : filt[0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_output <= 2'h0;
      core_in <= 4'h0;
      irq <= 1'b0;
    end else begin
      hs_output <= out_nxt;
      core_in <= in_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

  // register file
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_RST;
      ctrl_r <= CTRL_RST;
      filt_cfg_r <= FILT_RST;
      status_r <= '0;
      mask_r <= '0;
      period_r <= PERIOD_RST;
      pulses_r <= PULSES_RST;
      timer_r <= TIMER_RST;
      pidx_r <= 5'h00;
    end else begin
      status_r <= status_nxt;
      if (wr_mode) mode_r <= hwdata[15:0];
      if (wr_ctrl) ctrl_r <= hwdata[9:0] & 10'h3f1;
      if (wr_filt) filt_cfg_r <= hwdata[15:0];
      if (wr_mask) mask_r <= hwdata[ST_W-1:0];
      if (wr_period) period_r <= hwdata;
      if (wr_pulses) pulses_r <= hwdata;
      if (wr_timer) timer_r <= hwdata[15:0];
      if (wr_pidx) pidx_r <= hwdata[4:0];
      else if (wr_preset) pidx_r <= pidx_r + 5'h01;
    end
  end

  always_comb begin
    case (raddr)
      OFS_MODE: rd_mux = {16'h0000, mode_r};
      OFS_CTRL: rd_mux = {22'h000000, ctrl_r};
      OFS_FILT: rd_mux = {16'h0000, filt_cfg_r};
      OFS_STATUS: rd_mux = {27'h0000000, status_nxt};
      OFS_MASK: rd_mux = {27'h0000000, mask_r};
      OFS_COUNT: rd_mux = 32'(count_r);
      OFS_PERIOD: rd_mux = period_r;
      OFS_PULSES: rd_mux = pulses_r;
      OFS_TIMER: rd_mux = {16'h0000, timer_r};
      OFS_PIDX: rd_mux = {27'h0000000, pidx_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 12'h000;
      rdata_r <= 32'h0;
    end else begin
      wr_pend_r <= acc & hwrite;
      waddr_r <= raddr;
      if (acc && !hwrite) rdata_r <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
endmodule : fast_io_unit

//--- verilog/preset_mem.sv
// preset table memory with registered read
`timescale 1ns/100ps
module preset_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 24,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
    end else if (int'(rd_addr) < DEPTH) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule : preset_mem
